// file: inc/field_edit_defines.vh
// Constants shared by the field edit control, its assertions and its testbench
`ifndef FIELD_EDIT_DEFINES_VH
`define FIELD_EDIT_DEFINES_VH

// Screen geometry
`define COLS 11'h050
`define LAST_POS 11'h77F
`define POS_COUNT 12'h780

// Keyboard codes
`define LEAD_IN_CODE 8'h1B
`define BG_START_CODE 8'h0F
`define FG_START_CODE 8'h10
`define PRINT_START_CODE 8'h1E
`define TRANSMIT_START_CODE 8'h0E
`define TAB_CODE 8'h09
`define CR_CODE 8'h0D
`define DELETE_CODE 8'h7F
`define SPACE_KEY_CODE 8'h20
`define TX_SYMBOL_CODE 8'h04

// Timing
`define CLK_MHZ 24'h000032
`define BLINK_US 24'h00C350

// Register byte offsets
`define REG_CONTROL 5'h00
`define REG_STATUS 5'h04
`define REG_CURSOR 5'h08
`define REG_MEM_ADDR 5'h0C
`define REG_MEM_DATA 5'h10

// Control fields
`define CTRL_BATCH_BIT 0
`define CTRL_BG_ENTRY_BIT 1
`define CTRL_PRINT_CLR_BIT 2
`define CTRL_XMIT_CLR_BIT 3
`define CTRL_RESET 2'h0

// Status fields
`define STAT_PRINT_BIT 0
`define STAT_XMIT_BIT 1
`define STAT_BUSY_BIT 2
`define STAT_BLINK_BIT 3
`define STAT_LEAD_BIT 4

// Cell layout: bit 8 is the background attribute
`define CELL_BG_BIT 8

`endif

// file: hdl/key_capture.v
`timescale 1ns/100ps
// Brings keyboard pins into the clock domain and emits one pulse per keystroke
module key_capture (
  // Clock and reset
  input wire clock,
  input wire srst,
  input wire ce,
  // Keyboard pins
  input wire key_strobe,
  input wire [7:0] key_code,
  input wire insert_key,
  // Synchronised keystroke
  output reg key_pulse,
  output reg [7:0] key_data,
  output reg insert_held
);

  reg [7:0] code_s1_q; // First stage, read only by second stage
  reg [7:0] code_s2_q; // Stable code
  reg strobe_s1_q; // First stage of strobe
  reg strobe_s2_q; // Synchronised strobe
  reg strobe_s3_q; // Previous synchronised strobe
  reg ins_s1_q; // First stage of insert key
  reg ins_s2_q; // Synchronised insert key

  // Two-stage synchronisers and rising edge detection on the strobe
  always @(posedge clock) begin
    if (srst) begin
      code_s1_q <= 8'h00;
      code_s2_q <= 8'h00;
      strobe_s1_q <= 1'b0;
      strobe_s2_q <= 1'b0;
      strobe_s3_q <= 1'b0;
      ins_s1_q <= 1'b0;
      ins_s2_q <= 1'b0;
      key_pulse <= 1'b0;
      key_data <= 8'h00;
      insert_held <= 1'b0;
    end else if (ce) begin
      code_s1_q <= key_code;
      code_s2_q <= code_s1_q;
      strobe_s1_q <= key_strobe;
      strobe_s2_q <= strobe_s1_q;
      strobe_s3_q <= strobe_s2_q;
      ins_s1_q <= insert_key;
      ins_s2_q <= ins_s1_q;
      key_pulse <= strobe_s2_q & ~strobe_s3_q;
      key_data <= code_s2_q;
      insert_held <= ins_s2_q;
    end
  end

endmodule // key_capture

// file: hdl/field_edit_control.v
`timescale 1ns/100ps
`include "field_edit_defines.vh"
module field_edit_control #(
  parameter [23:0] BLINK_CYCLES = `BLINK_US * `CLK_MHZ
) (
  // Clock, reset, enable
  input wire clock,
  input wire srst,
  input wire ce,
  // Avalon-MM slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Keyboard pins
  input wire key_strobe,
  input wire [7:0] key_code,
  input wire insert_key,
  // Transmit path
  output reg [7:0] tx_data,
  output reg tx_valid,
  input wire tx_ready,
  // Indicators
  output reg print_lamp,
  output reg transmit_lamp,
  output reg blink
);

  // One-hot sequencer states
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_FIND = 7'h02;
  localparam [6:0] S_SHR = 7'h04;
  localparam [6:0] S_SHL = 7'h08;
  localparam [6:0] S_TAB = 7'h10;
  localparam [6:0] S_SCAN = 7'h20;
  localparam [6:0] S_SYM = 7'h40;

  reg [8:0] screen_q [0:`POS_COUNT-1]; // Character plus protection bit per cell
  reg [6:0] state_q; // Sequencer state
  reg [10:0] cursor_q; // Cursor position
  reg [10:0] ptr_q; // Working pointer of the sequencer
  reg [10:0] mem_addr_q; // Software window into the screen
  reg lead_q; // Lead-in seen, next code is a command
  reg bg_entry_q; // Typed characters stored as background
  reg batch_q; // Batch mode selected
  reg found_q; // Tab: foreground seen; symbols: second one due
  reg prev_bg_q; // Tab: previous cell was background
  reg [7:0] ins_char_q; // Character waiting to be inserted
  reg pending_q; // Keystroke waiting for the sequencer
  reg [7:0] pend_code_q; // Its code
  reg pend_ins_q; // Insert key was held with it
  reg ack_q; // Bus request answered
  reg [23:0] blink_cnt_q; // Blink duration counter
  wire key_pulse; // One pulse per keystroke
  wire [7:0] key_data; // Keystroke code
  wire insert_held; // Insert key level

  // Keyboard capture
  key_capture u_keys (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .key_strobe(key_strobe),
    .key_code(key_code),
    .insert_key(insert_key),
    .key_pulse(key_pulse),
    .key_data(key_data),
    .insert_held(insert_held)
  );

  // Position arithmetic
  wire [10:0] cur_col = cursor_q % `COLS;
  wire [10:0] line_first = cursor_q - cur_col;
  wire [10:0] ptr_col = ptr_q % `COLS;
  wire ptr_line_end = (ptr_col == `COLS - 11'h001);
  wire ptr_line_start = (ptr_col == 11'h000);
  wire [10:0] ptr_next = ptr_q + 11'h001;
  wire [10:0] ptr_prev = ptr_q - 11'h001;
  wire [10:0] cur_next = (cursor_q == `LAST_POS) ? cursor_q : cursor_q + 11'h001;
  wire [10:0] next_line = (line_first + `COLS > `LAST_POS) ? 11'd0 : line_first + `COLS;

  // Cell reads
  wire [8:0] cell_cur = screen_q[cursor_q];
  wire [8:0] cell_ptr = screen_q[ptr_q];
  wire [8:0] cell_next = ptr_line_end ? 9'h000 : screen_q[ptr_next];
  wire [8:0] cell_prev = ptr_line_start ? 9'h000 : screen_q[ptr_prev];
  wire [8:0] cell_bus = (mem_addr_q > `LAST_POS) ? 9'h000 : screen_q[mem_addr_q];
  wire next_is_fg = ~ptr_line_end & ~cell_next[`CELL_BG_BIT];

  // Handshake
  wire idle = (state_q == S_IDLE);
  wire consume = idle & pending_q;
  wire bus_req = avs_read | avs_write;
  wire serve = bus_req & ~ack_q & idle & ~pending_q;
  wire printable = (pend_code_q >= `SPACE_KEY_CODE) && (pend_code_q < `DELETE_CODE);
  assign avs_waitrequest = bus_req & ~ack_q;

  // Command decode, editing sequencer, screen writes and register access
  always @(posedge clock) begin
    if (srst) begin
      state_q <= S_IDLE;
      cursor_q <= 11'h000;
      ptr_q <= 11'h000;
      mem_addr_q <= 11'h000;
      lead_q <= 1'b0;
      bg_entry_q <= 1'b0;
      batch_q <= 1'b0;
      found_q <= 1'b0;
      prev_bg_q <= 1'b0;
      ins_char_q <= 8'h00;
      pending_q <= 1'b0;
      pend_code_q <= 8'h00;
      pend_ins_q <= 1'b0;
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      print_lamp <= 1'b0;
      transmit_lamp <= 1'b0;
      blink <= 1'b0;
      blink_cnt_q <= 24'h000000;
    end else if (ce) begin
      ack_q <= serve;
      // Keystroke holding; a new key wins over the consume
      if (key_pulse) begin
        pending_q <= 1'b1;
        pend_code_q <= key_data;
        pend_ins_q <= insert_held;
      end else if (consume) begin
        pending_q <= 1'b0;
      end
      // Blink countdown
      if (blink_cnt_q != 24'h000000) begin
        blink_cnt_q <= blink_cnt_q - 24'h000001;
      end else begin
        blink <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (consume) begin
            if (lead_q) begin
              // Command after the lead-in
              lead_q <= 1'b0;
              case (pend_code_q)
                `BG_START_CODE: begin
                  bg_entry_q <= 1'b1;
                end
                `FG_START_CODE: begin
                  bg_entry_q <= 1'b0;
                end
                `PRINT_START_CODE: begin
                  print_lamp <= 1'b1;
                  ptr_q <= cursor_q;
                  found_q <= 1'b0;
                  state_q <= S_SYM;
                end
                `TRANSMIT_START_CODE: begin
                  transmit_lamp <= 1'b1;
                  ptr_q <= 11'h000;
                  state_q <= S_SCAN;
                end
                default: begin
                  lead_q <= 1'b0;
                end
              endcase
            end else if (pend_code_q == `LEAD_IN_CODE) begin
              lead_q <= 1'b1;
            end else if (pend_ins_q && printable) begin
              // Insert character
              if (cell_cur[`CELL_BG_BIT]) begin
                blink <= 1'b1;
                blink_cnt_q <= BLINK_CYCLES - 24'h000001;
              end else begin
                ins_char_q <= pend_code_q;
                ptr_q <= cursor_q;
                state_q <= S_FIND;
              end
            end else begin
              case (pend_code_q)
                `PRINT_START_CODE, `TRANSMIT_START_CODE, `BG_START_CODE: begin
                  // Bare print, transmit and background codes write a blank and step right
                  screen_q[cursor_q] <= {bg_entry_q, `SPACE_KEY_CODE};
                  cursor_q <= cur_next;
                end
                `TAB_CODE: begin
                  ptr_q <= cur_next;
                  found_q <= 1'b0;
                  prev_bg_q <= cell_cur[`CELL_BG_BIT];
                  if (cursor_q != `LAST_POS) begin
                    state_q <= S_TAB;
                  end
                end
                `CR_CODE: begin
                  cursor_q <= next_line;
                end
                `DELETE_CODE: begin
                  if (cell_cur[`CELL_BG_BIT]) begin
                    blink <= 1'b1;
                    blink_cnt_q <= BLINK_CYCLES - 24'h000001;
                  end else begin
                    ptr_q <= cursor_q;
                    state_q <= S_SHL;
                  end
                end
                default: begin
                  if (printable) begin
                    // Protected cells in batch mode keep their contents unless background entry is selected
                    if (!(cell_cur[`CELL_BG_BIT] && batch_q && !bg_entry_q)) begin
                      screen_q[cursor_q] <= {bg_entry_q, pend_code_q};
                    end
                    cursor_q <= cur_next;
                  end
                end
              endcase
            end
          end else if (serve) begin
            // Register access
            avs_readdata <= 32'h00000000;
            case (avs_address)
              `REG_CONTROL: begin
                if (avs_write) begin
                  batch_q <= avs_writedata[`CTRL_BATCH_BIT];
                  bg_entry_q <= avs_writedata[`CTRL_BG_ENTRY_BIT];
                  if (avs_writedata[`CTRL_PRINT_CLR_BIT]) begin
                    print_lamp <= 1'b0;
                  end
                  if (avs_writedata[`CTRL_XMIT_CLR_BIT]) begin
                    transmit_lamp <= 1'b0;
                  end
                end
                avs_readdata[`CTRL_BATCH_BIT] <= batch_q;
                avs_readdata[`CTRL_BG_ENTRY_BIT] <= bg_entry_q;
              end
              `REG_STATUS: begin
                avs_readdata[`STAT_PRINT_BIT] <= print_lamp;
                avs_readdata[`STAT_XMIT_BIT] <= transmit_lamp;
                avs_readdata[`STAT_BUSY_BIT] <= 1'b0;
                avs_readdata[`STAT_BLINK_BIT] <= blink;
                avs_readdata[`STAT_LEAD_BIT] <= lead_q;
              end
              `REG_CURSOR: begin
                if (avs_write && avs_writedata[10:0] <= `LAST_POS) begin
                  cursor_q <= avs_writedata[10:0];
                end
                avs_readdata[10:0] <= cursor_q;
              end
              `REG_MEM_ADDR: begin
                if (avs_write) begin
                  mem_addr_q <= avs_writedata[10:0];
                end
                avs_readdata[10:0] <= mem_addr_q;
              end
              `REG_MEM_DATA: begin
                if (avs_write && mem_addr_q <= `LAST_POS) begin
                  screen_q[mem_addr_q] <= avs_writedata[8:0];
                end
                avs_readdata[8:0] <= cell_bus;
              end
              default: begin
                avs_readdata <= 32'h00000000;
              end
            endcase
          end
        end
        S_TAB: begin
          // Field start: foreground cell at line start or after background
          if (!cell_ptr[`CELL_BG_BIT] && (ptr_line_start || prev_bg_q)) begin
            cursor_q <= ptr_q;
            state_q <= S_IDLE;
          end else if (ptr_q == `LAST_POS) begin
            if (found_q || !cell_ptr[`CELL_BG_BIT]) begin
              cursor_q <= `LAST_POS;
            end
            state_q <= S_IDLE;
          end else begin
            found_q <= found_q | ~cell_ptr[`CELL_BG_BIT];
            prev_bg_q <= cell_ptr[`CELL_BG_BIT];
            ptr_q <= ptr_next;
          end
        end
        S_FIND: begin
          // Walk to the end of the foreground run on this line
          if (next_is_fg) begin
            ptr_q <= ptr_next;
          end else begin
            state_q <= S_SHR;
          end
        end
        S_SHR: begin
          // Shift right from the run end back to the cursor
          if (ptr_q == cursor_q) begin
            screen_q[ptr_q] <= {1'b0, ins_char_q};
            state_q <= S_IDLE;
          end else begin
            screen_q[ptr_q] <= cell_prev;
            ptr_q <= ptr_prev;
          end
        end
        S_SHL: begin
          // Pull the run left by one, blank its last cell
          if (next_is_fg) begin
            screen_q[ptr_q] <= cell_next;
            ptr_q <= ptr_next;
          end else begin
            screen_q[ptr_q] <= {1'b0, `SPACE_KEY_CODE};
            state_q <= S_IDLE;
          end
        end
        S_SYM: begin
          // Two transmit symbols from the cursor onward
          screen_q[ptr_q] <= {1'b0, `TX_SYMBOL_CODE};
          if (found_q || ptr_q == `LAST_POS) begin
            state_q <= S_IDLE;
          end else begin
            found_q <= 1'b1;
            ptr_q <= ptr_next;
          end
        end
        S_SCAN: begin
          // Whole-screen scan; cursor follows, protected cells are passed over
          cursor_q <= ptr_q;
          if (tx_valid) begin
            if (tx_ready) begin
              tx_valid <= 1'b0;
              if (ptr_q == `LAST_POS) begin
                transmit_lamp <= 1'b0;
                state_q <= S_IDLE;
              end else begin
                ptr_q <= ptr_next;
              end
            end
          end else if (!cell_ptr[`CELL_BG_BIT]) begin
            tx_data <= cell_ptr[7:0];
            tx_valid <= 1'b1;
          end else if (ptr_q == `LAST_POS) begin
            transmit_lamp <= 1'b0;
            state_q <= S_IDLE;
          end else begin
            ptr_q <= ptr_next;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // field_edit_control

// file: verif/field_edit_asserts.sv
`timescale 1ns/100ps
`include "field_edit_defines.vh"
module field_edit_asserts #(
  parameter [23:0] BLINK_CYCLES = `BLINK_US * `CLK_MHZ
) (
  // Clock, reset, enable
  input wire clock,
  input wire srst,
  input wire ce,
  // Bus write request
  input wire avs_write,
  // Keyboard pins
  input wire key_strobe,
  input wire [7:0] key_code,
  input wire insert_key,
  // Transmit path and lamps
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire print_lamp,
  input wire transmit_lamp,
  input wire blink
);
  reg strobe_q; // Strobe at the previous edge
  reg [7:0] last_q; // Newest keystroke code
  reg [7:0] prev_q; // Keystroke before the newest
  reg [23:0] cnt_q; // Cycles blink has been high

  // Record keystroke codes and time the blink
  always @(posedge clock) begin
    if (srst) begin
      strobe_q <= 1'b0;
      last_q <= 8'h00;
      prev_q <= 8'h00;
      cnt_q <= 24'h0;
    end else if (ce) begin
      strobe_q <= key_strobe;
      cnt_q <= blink ? cnt_q + 24'h1 : 24'h0;
      if (key_strobe && !strobe_q) begin
        last_q <= key_code;
        prev_q <= last_q;
      end
    end
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (srst);

  print_lamp_on_a: assert property ($rose(print_lamp) |-> prev_q == `LEAD_IN_CODE && last_q == `PRINT_START_CODE)
    else $error("print lamp lit without prefixed print code");
  print_lamp_hold_a: assert property (print_lamp && !avs_write |=> print_lamp)
    else $error("print lamp dropped without a control write");
  xmit_lamp_on_a: assert property ($rose(transmit_lamp) |-> prev_q == `LEAD_IN_CODE && last_q == `TRANSMIT_START_CODE)
    else $error("transmit lamp lit without prefixed transmit code");
  tx_mode_a: assert property (tx_valid |-> transmit_lamp)
    else $error("character offered outside transmit mode");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("transmit character not held until taken");
  blink_len_a: assert property ($fell(blink) |-> cnt_q == BLINK_CYCLES)
    else $error("blink length wrong");
  blink_max_a: assert property (blink |-> cnt_q < BLINK_CYCLES)
    else $error("blink too long");
  blink_cause_a: assert property ($rose(blink) |-> insert_key || last_q == `DELETE_CODE)
    else $error("blink without insert or delete");
endmodule // field_edit_asserts

bind field_edit_control field_edit_asserts #(.BLINK_CYCLES(BLINK_CYCLES)) chk (.clock(clock), .srst(srst), .ce(ce),
  .avs_write(avs_write), .key_strobe(key_strobe), .key_code(key_code), .insert_key(insert_key), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .print_lamp(print_lamp), .transmit_lamp(transmit_lamp), .blink(blink));

// file: verif/keyboard_model.sv
`timescale 1ns/100ps
module keyboard_model (
  // Clock
  input wire clock,
  // Keyboard pins
  output logic key_strobe,
  output logic [7:0] key_code,
  output logic insert_key
);
  // Idle pins at time zero
  initial begin
    key_strobe = 1'b0;
    key_code = 8'h00;
    insert_key = 1'b0;
  end

  // One keystroke: code settles before the strobe, then scrambles after it
  task press(input logic [7:0] c);
    @(posedge clock);
    key_code <= c;
    repeat (4) @(posedge clock);
    key_strobe <= 1'b1;
    repeat (4) @(posedge clock);
    key_strobe <= 1'b0;
    key_code <= ~c;
    repeat (4) @(posedge clock);
  endtask

  // Press or let go of the insert key
  task hold_insert(input logic on);
    @(posedge clock);
    insert_key <= on;
  endtask
endmodule // keyboard_model

// file: verif/testbench.sv
`timescale 1ns/100ps
`include "field_edit_defines.vh"
module testbench;
  localparam [23:0] BLINK_CYCLES = 24'h8; // Short blink
  reg clock = 1'b0;
  reg srst = 1'b1;
  reg ce = 1'b1;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg tx_ready = 1'b0;
  reg [4:0] avs_address = 5'h00;
  reg [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, key_strobe, insert_key, tx_valid, print_lamp, transmit_lamp, blink;
  wire [7:0] key_code, tx_data;
  reg [8:0] shadow [0:1919]; // Expected screen
  reg [7:0] txq [$]; // Characters taken from transmit path
  reg [31:0] rd;
  reg blink_seen = 1'b0;
  reg xmit_seen = 1'b0;
  integer err_count = 0, cmp_count = 0, cycles = 0, i, n;

  field_edit_control #(.BLINK_CYCLES(BLINK_CYCLES)) dut (.clock(clock), .srst(srst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .key_strobe(key_strobe), .key_code(key_code),
    .insert_key(insert_key), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .print_lamp(print_lamp), .transmit_lamp(transmit_lamp), .blink(blink));
  keyboard_model kb (.clock(clock), .key_strobe(key_strobe), .key_code(key_code), .insert_key(insert_key));

  // 50 MHz clock
  initial begin
    forever #10 clock = ~clock;
  end

  // Stalling sink, sticky flags and timeout
  always @(posedge clock) begin
    cycles = cycles + 1;
    tx_ready <= ~tx_ready;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_data);
    if (blink === 1'b1) blink_seen = 1'b1;
    if (transmit_lamp === 1'b1) xmit_seen = 1'b1;
    if (cycles == 80000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end

  task end_sim;
    $display("Mismatches %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input reg [31:0] seen, input reg [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low
  task bus(input reg wr_en, input reg [4:0] a, input reg [31:0] d, output reg [31:0] r);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr(input reg [4:0] a, input reg [31:0] d);
    reg [31:0] t;
    bus(1'b1, a, d, t);
  endtask

  task rchk(input reg [4:0] a, input reg [31:0] exp);
    reg [31:0] t;
    bus(1'b0, a, 32'h0, t);
    chk(t, exp);
  endtask

  // Compare a range of screen cells with the expected screen
  task cells(input integer lo, input integer hi);
    integer a;
    for (a = lo; a <= hi; a = a + 1) begin
      wr(`REG_MEM_ADDR, a);
      rchk(`REG_MEM_DATA, {23'h0, shadow[a]});
    end
  endtask

  // Keystroke, then a status read that waits for the edit to finish
  task key(input reg [7:0] c);
    kb.press(c);
    bus(1'b0, `REG_STATUS, 32'h0, rd);
  endtask

  task ins_key(input reg [7:0] c);
    kb.hold_insert(1'b1);
    key(c);
    kb.hold_insert(1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    rchk(`REG_CONTROL, 32'h0);
    rchk(`REG_CURSOR, 32'h0);
    rchk(5'h14, 32'h0);
    // Two short foreground fields on rows 0 and 1, background elsewhere
    for (i = 0; i < `POS_COUNT; i = i + 1) begin
      shadow[i] = (i < 160 && i % 80 >= 4 && i % 80 < 12) ? 9'h030 + i % 80 : 9'h12E;
      wr(`REG_MEM_ADDR, i);
      wr(`REG_MEM_DATA, shadow[i]);
    end
    key(`TAB_CODE);
    rchk(`REG_CURSOR, 32'h4);
    key(`TAB_CODE);
    rchk(`REG_CURSOR, 32'h54);
    key(`TAB_CODE);
    rchk(`REG_CURSOR, 32'h77F);
    key(`TAB_CODE);
    rchk(`REG_CURSOR, 32'h77F);
    wr(`REG_CURSOR, 32'h54);
    ins_key(8'h58);
    for (i = 91; i > 84; i = i - 1) shadow[i] = shadow[i - 1];
    shadow[84] = 9'h058;
    cells(0, 95);
    rchk(`REG_CURSOR, 32'h54);
    key(`DELETE_CODE);
    for (i = 84; i < 91; i = i + 1) shadow[i] = shadow[i + 1];
    shadow[91] = 9'h020;
    cells(0, 95);
    rchk(`REG_CURSOR, 32'h54);
    wr(`REG_CURSOR, 32'h0);
    ins_key(8'h58);
    chk(blink_seen, 32'h1);
    key(`DELETE_CODE);
    cells(0, 3);
    rchk(`REG_CURSOR, 32'h0);
    wr(`REG_CURSOR, 32'h4);
    key(`PRINT_START_CODE);
    shadow[4] = 9'h020;
    cells(4, 4);
    rchk(`REG_CURSOR, 32'h5);
    key(`LEAD_IN_CODE);
    chk(rd, 32'h10);
    key(`BG_START_CODE);
    rchk(`REG_CURSOR, 32'h5);
    key(8'h5A);
    shadow[5] = 9'h15A;
    cells(5, 5);
    key(`LEAD_IN_CODE);
    key(`FG_START_CODE);
    key(`LEAD_IN_CODE);
    key(`PRINT_START_CODE);
    chk(print_lamp, 32'h1);
    shadow[6] = 9'h004;
    shadow[7] = 9'h004;
    cells(4, 8);
    rchk(`REG_CURSOR, 32'h6);
    wr(`REG_CONTROL, 32'h4);
    rchk(`REG_STATUS, 32'h0);
    wr(`REG_CONTROL, 32'h1);
    wr(`REG_CURSOR, 32'h0);
    key(`SPACE_KEY_CODE);
    key(8'h51);
    rchk(`REG_CURSOR, 32'h2);
    key(`CR_CODE);
    cells(0, 3);
    rchk(`REG_CURSOR, 32'h50);
    wr(`REG_CONTROL, 32'h0);
    // Bare transmit code on a protected cell writes a foreground blank
    key(`TRANSMIT_START_CODE);
    shadow[80] = 9'h020;
    cells(80, 80);
    rchk(`REG_CURSOR, 32'h51);
    txq.delete();
    key(`LEAD_IN_CODE);
    key(`TRANSMIT_START_CODE);
    chk(xmit_seen, 32'h1);
    chk(transmit_lamp, 32'h0);
    n = 0;
    for (i = 0; i < `POS_COUNT; i = i + 1) begin
      if (shadow[i][8] === 1'b0) begin
        chk(txq[n], shadow[i][7:0]);
        n = n + 1;
      end
    end
    chk(txq.size(), n);
    end_sim;
  end
endmodule // testbench
